// ### hdl/imv_unit.sv
// Purpose: interrupt mask and vector unit with posted flags and priority vector
// Assumes: register port single-cycle strobes, read data one cycle later
// Notes:   source 0 has the highest priority and the vector VEC_BASE
//
// Summary of operation
// - soft enable low: written zeros clear posts
// - soft enable high: written ones post interrupts
// - enable bit 0 masks, 1 unmasks
// - group 2 enables ports, PS/2, ext2, wrap, capture1
// - group 1 enables capture0, timers, USB sources
// - group 0 enables ports, sleep, SPI, ext, power
// - vector read gives highest-priority pending vector
// - any vector write clears all pending
// - masked sources still post
// - soft enable high: written zeros ignored
// - soft enable low: written ones ignored
// - clear register reads show posted flags
`timescale 1ns/10ps
`default_nettype none
module imv_unit (
    input  wire logic                  core_clk,
    input  wire logic                  reset,
    input  wire imv_pkg::imv_bus_req_t bus,
    output logic [imv_pkg::DW-1:0]     bus_rdata,
    input  wire logic [imv_pkg::NSRC-1:0] src_event,
    output logic                       int_req,
    output logic [imv_pkg::DW-1:0]     int_vector,
    output logic                       irq
);
    import imv_pkg::*;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic            soft_q,  soft_d;
    logic [DW-1:0]   en0_q,   en0_d;
    logic [DW-1:0]   en1_q,   en1_d;
    logic [G2W-1:0]  en2_q,   en2_d;
    logic [ST_W-1:0] stat_q,  stat_d;
    logic [ST_W-1:0] imask_q, imask_d;
    logic [DW-1:0]   rdata_q, rdata_d;
    logic [DW-1:0]   vec_q,   vec_d;
    logic            req_q,   req_d;
    logic            irq_q,   irq_d;
    logic            any_q;

    logic [NSRC-1:0] posted;
    logic [NSRC-1:0] enables;
    logic [NSRC-1:0] pending;
    logic [NSRC-1:0] vc_clr;
    logic            any_pend;
    logic            wr_clr0, wr_clr1, wr_clr2, wr_vc, rd_vc;
    logic [ST_W-1:0] st_ev;

    assign wr_clr0 = bus.wr && (bus.addr == OFS_CLR0);
    assign wr_clr1 = bus.wr && (bus.addr == OFS_CLR1);
    assign wr_clr2 = bus.wr && (bus.addr == OFS_CLR2);
    assign wr_vc   = bus.wr && (bus.addr == OFS_VC);
    assign rd_vc   = bus.rd && (bus.addr == OFS_VC);

    // ------------------------------------------------------------
    // posted flags and pending
    // ------------------------------------------------------------
    // source bit placement
    assign enables  = {en2_q, en1_q, en0_q};
    assign pending  = posted & enables;
    assign any_pend = |pending;
    assign vc_clr   = wr_vc ? pending : '0;

    imv_posted_bank #(.W(DW)) u_bank0 (
        .core_clk        (core_clk),
        .reset           (reset),
        .src_event       (src_event[DW-1:0]),
        .wr_sel          (wr_clr0),
        .soft_int_enable (soft_q),
        .wdata           (bus.wdata),
        .vc_clr          (vc_clr[DW-1:0]),
        .posted          (posted[DW-1:0])
    );

    imv_posted_bank #(.W(DW)) u_bank1 (
        .core_clk        (core_clk),
        .reset           (reset),
        .src_event       (src_event[2*DW-1:DW]),
        .wr_sel          (wr_clr1),
        .soft_int_enable (soft_q),
        .wdata           (bus.wdata),
        .vc_clr          (vc_clr[2*DW-1:DW]),
        .posted          (posted[2*DW-1:DW])
    );

    // reserved top bit of group 2 has no flag at all
    imv_posted_bank #(.W(G2W)) u_bank2 (
        .core_clk        (core_clk),
        .reset           (reset),
        .src_event       (src_event[NSRC-1:2*DW]),
        .wr_sel          (wr_clr2),
        .soft_int_enable (soft_q),
        .wdata           (bus.wdata[G2W-1:0]),
        .vc_clr          (vc_clr[NSRC-1:2*DW]),
        .posted          (posted[NSRC-1:2*DW])
    );

    // ------------------------------------------------------------
    // priority vector
    // ------------------------------------------------------------
    always_comb begin
        vec_d = VEC_NONE;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (pending[i]) begin
                vec_d = VEC_BASE + DW'(i) * VEC_STEP;
            end
        end
        req_d = any_pend;
    end

    // ------------------------------------------------------------
    // control registers and event status
    // ------------------------------------------------------------
    always_comb begin
        soft_d  = soft_q;
        en0_d   = en0_q;
        en1_d   = en1_q;
        en2_d   = en2_q;
        imask_d = imask_q;
        st_ev   = '0;
        st_ev[ST_NEW]  = any_pend && !any_q;
        st_ev[ST_SOFT] = soft_q && (wr_clr0 || wr_clr1 || wr_clr2) && (|bus.wdata);
        st_ev[ST_VCLR] = wr_vc;
        stat_d  = stat_q;
        if (bus.wr) begin
            if (bus.addr == OFS_CTL) begin
                soft_d = bus.wdata[SOFT_BIT];
            end else if (bus.addr == OFS_EN2) begin
                en2_d = bus.wdata[G2W-1:0];
            end else if (bus.addr == OFS_EN1) begin
                en1_d = bus.wdata;
            end else if (bus.addr == OFS_EN0) begin
                en0_d = bus.wdata;
            end else if (bus.addr == OFS_STAT) begin
                stat_d = stat_q & ~bus.wdata[ST_W-1:0];
            end else if (bus.addr == OFS_IMASK) begin
                imask_d = bus.wdata[ST_W-1:0];
            end
        end
        // a new event beats a write-one clear in the same cycle
        stat_d = stat_d | st_ev;
        irq_d  = |(stat_d & imask_d);
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = RST_BYTE;
        if (bus.rd) begin
            if (bus.addr == OFS_CLR0) begin
                rdata_d = posted[DW-1:0];
            end else if (bus.addr == OFS_CLR1) begin
                rdata_d = posted[2*DW-1:DW];
            end else if (bus.addr == OFS_CLR2) begin
                rdata_d = {1'b0, posted[NSRC-1:2*DW]};
            end else if (bus.addr == OFS_CTL) begin
                rdata_d = {soft_q, 7'h00};
            end else if (bus.addr == OFS_EN2) begin
                rdata_d = {1'b0, en2_q} & EN2_MASK;
            end else if (bus.addr == OFS_EN1) begin
                rdata_d = en1_q;
            end else if (bus.addr == OFS_EN0) begin
                rdata_d = en0_q;
            end else if (bus.addr == OFS_VC) begin
                rdata_d = vec_d;
            end else if (bus.addr == OFS_STAT) begin
                rdata_d = {5'h00, stat_q};
            end else if (bus.addr == OFS_IMASK) begin
                rdata_d = {5'h00, imask_q};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            soft_q  <= 1'b0;
            en0_q   <= RST_BYTE;
            en1_q   <= RST_BYTE;
            en2_q   <= '0;
            stat_q  <= RST_ST;
            imask_q <= RST_ST;
            rdata_q <= RST_BYTE;
            vec_q   <= VEC_NONE;
            req_q   <= 1'b0;
            irq_q   <= 1'b0;
            any_q   <= 1'b0;
        end else begin
            soft_q  <= soft_d;
            en0_q   <= en0_d;
            en1_q   <= en1_d;
            en2_q   <= en2_d;
            stat_q  <= stat_d;
            imask_q <= imask_d;
            rdata_q <= rdata_d;
            vec_q   <= vec_d;
            req_q   <= req_d;
            irq_q   <= irq_d;
            any_q   <= any_pend;
        end
    end

    assign bus_rdata  = rdata_q;
    assign int_vector = vec_q;
    assign int_req    = req_q;
    assign irq        = irq_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_hw_clr0;
        wr_clr0 && !soft_q && (src_event[DW-1:0] == 8'h00);
    endsequence

    sequence s_sw_clr0;
        wr_clr0 && soft_q;
    endsequence

    a_zero_clears: assert property (
        s_hw_clr0 |=> ((posted[DW-1:0] & ~$past(bus.wdata)) == 8'h00))
        else $error("zero written with soft enable low did not clear");

    a_one_posts: assert property (
        s_sw_clr0 |=> ((posted[DW-1:0] & $past(bus.wdata)) == $past(bus.wdata)))
        else $error("one written with soft enable high did not post");

    a_mask_gates: assert property (
        ((en0_q == '0) && (en1_q == '0) && (en2_q == '0)) |=> !int_req)
        else $error("request raised with every source masked");

    a_vector_read: assert property (
        (rd_vc && !any_pend) |=> (bus_rdata == VEC_NONE))
        else $error("vector read with nothing pending is not zero");

    a_vector_low: assert property (
        (rd_vc && pending[0]) |=> (bus_rdata == VEC_BASE))
        else $error("top priority source not returned as vector");

    a_vc_clears: assert property (
        (wr_vc && (src_event == '0)) |=> (pending == '0) ##1 !int_req)
        else $error("vector write left an interrupt pending");

    a_masked_posts: assert property (
        (src_event[0] && !en0_q[0] && !(bus.wr && bus.addr == OFS_EN0))
            |=> posted[0] ##0 !pending[0] [*1])
        else $error("masked source failed to post");

    a_zeros_ignored: assert property (
        s_sw_clr0 |=> ((posted[DW-1:0] & $past(posted[DW-1:0])) == $past(posted[DW-1:0])))
        else $error("zero written with soft enable high cleared a flag");

    a_ones_ignored: assert property (
        s_hw_clr0 |=> ((posted[DW-1:0] & ~$past(posted[DW-1:0])) == 8'h00))
        else $error("one written with soft enable low posted a flag");

    a_read_posted: assert property (
        (bus.rd && bus.addr == OFS_CLR1) |=> (bus_rdata == $past(posted[2*DW-1:DW])))
        else $error("clear register read does not show posted flags");

    a_group0_place: assert property (
        (bus.wr && bus.addr == OFS_EN0) |=> (enables[DW-1:0] == $past(bus.wdata)))
        else $error("group 0 enable write landed in the wrong bits");

    a_group1_place: assert property (
        (bus.wr && bus.addr == OFS_EN1) |=> (enables[2*DW-1:DW] == $past(bus.wdata)))
        else $error("group 1 enable write landed in the wrong bits");

    a_group2_place: assert property (
        (bus.wr && bus.addr == OFS_EN2)
            |=> (enables[NSRC-1:2*DW] == $past(bus.wdata[G2W-1:0])))
        else $error("group 2 enable write landed in the wrong bits");

    a_group2_read: assert property (
        (bus.rd && bus.addr == OFS_CLR2)
            |=> (bus_rdata == {1'b0, $past(posted[NSRC-1:2*DW])}))
        else $error("group 2 posted flags not read back with bit 7 low");

    a_request_follows: assert property (
        any_pend |=> int_req)
        else $error("pending interrupt gave no request");

    a_vector_next: assert property (
        (pending[1] && !pending[0]) |=> (int_vector == (VEC_BASE + VEC_STEP)))
        else $error("second source pending alone gave the wrong vector");

    a_reset_masks: assert property (@(posedge core_clk) disable iff (1'b0)
        reset |=> (!soft_q && enables == '0 && !int_req && !irq))
        else $error("reset left an enable or request active");
endmodule : imv_unit
`default_nettype wire

// ### hdl/imv_pkg.sv
// Purpose: shared constants and types of the interrupt mask and vector unit
// Assumes: 8-bit register port, one clock, synchronous active-high reset
// Notes:   offsets are byte addresses on the plain register port
package imv_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int unsigned DW   = 8;
    localparam int unsigned AW   = 8;
    localparam int unsigned NSRC = 23;
    localparam int unsigned G2W  = 7;
    localparam int unsigned ST_W = 3;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [AW-1:0] OFS_CLR0  = 8'hDA;
    localparam logic [AW-1:0] OFS_CLR1  = 8'hDB;
    localparam logic [AW-1:0] OFS_CLR2  = 8'hDC;
    localparam logic [AW-1:0] OFS_CTL   = 8'hDE;
    localparam logic [AW-1:0] OFS_EN2   = 8'hDF;
    localparam logic [AW-1:0] OFS_EN1   = 8'hE0;
    localparam logic [AW-1:0] OFS_EN0   = 8'hE1;
    localparam logic [AW-1:0] OFS_VC    = 8'hE2;
    localparam logic [AW-1:0] OFS_STAT  = 8'hE3;
    localparam logic [AW-1:0] OFS_IMASK = 8'hE4;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int unsigned   SOFT_BIT = 7;
    localparam logic [DW-1:0] RST_BYTE = 8'h00;
    localparam logic [DW-1:0] EN2_MASK = 8'h7F;
    localparam logic [DW-1:0] VEC_BASE = 8'h04;
    localparam logic [DW-1:0] VEC_STEP = 8'h04;
    localparam logic [DW-1:0] VEC_NONE = 8'h00;
    localparam int unsigned   ST_NEW   = 0;
    localparam int unsigned   ST_SOFT  = 1;
    localparam int unsigned   ST_VCLR  = 2;
    localparam logic [ST_W-1:0] RST_ST = 3'h0;

    // ------------------------------------------------------------
    // register port request
    // ------------------------------------------------------------
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          wr;
        logic          rd;
    } imv_bus_req_t;
endpackage : imv_pkg

// ### hdl/imv_posted_bank.sv
// Purpose: one group of posted interrupt flags with its clear register
// Assumes: source events are one-cycle pulses from the core_clk domain
// Notes:   a hardware event always wins over any clear in the same cycle
`timescale 1ns/10ps
`default_nettype none
module imv_posted_bank #(
    parameter int unsigned W = 8
) (
    input  wire logic         core_clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] src_event,
    input  wire logic         wr_sel,
    input  wire logic         soft_int_enable,
    input  wire logic [W-1:0] wdata,
    input  wire logic [W-1:0] vc_clr,
    output logic      [W-1:0] posted
);
    import imv_pkg::*;

    logic [W-1:0] posted_q;
    logic [W-1:0] posted_d;
    logic [W-1:0] set_v;
    logic [W-1:0] clr_v;

    always_comb begin
        set_v = src_event | ({W{wr_sel & soft_int_enable}} & wdata);
        clr_v = ({W{wr_sel & ~soft_int_enable}} & ~wdata) | vc_clr;
        posted_d = set_v | (posted_q & ~clr_v);
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            posted_q <= '0;
        end else begin
            posted_q <= posted_d;
        end
    end

    assign posted = posted_q;
endmodule : imv_posted_bank
`default_nettype wire

// ### verification/imv_src_model.sv
// Purpose: peripheral source model that raises interrupt events
// Assumes: one core_clk domain, synchronous active-high reset
// Notes:   each request bit is registered into its event bit one cycle later
`timescale 1ns/10ps
`default_nettype none
module imv_src_model (
    input  wire logic                     core_clk,
    input  wire logic                     reset,
    input  wire logic [imv_pkg::NSRC-1:0] fire,
    output logic      [imv_pkg::NSRC-1:0] src_event
);
    import imv_pkg::*;
    logic [NSRC-1:0] event_q;
    logic [NSRC-1:0] event_d;

    // registered so events leave right after an edge, like real sources
    always_comb begin
        event_d = reset ? '0 : fire;
    end
    always_ff @(posedge core_clk) begin
        event_q <= event_d;
    end
    assign src_event = event_q;
endmodule : imv_src_model
`default_nettype wire

// ### verification/testbench.sv
// Purpose: register-level tests of the interrupt mask and vector unit
// Assumes: one-cycle strobes, read data only in the cycle after the read
// Notes:   status and mask at 0xE3/0xE4 are block-local additions
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import imv_pkg::*;
    logic            core_clk;
    logic            reset;
    imv_bus_req_t    bus;
    logic [DW-1:0]   bus_rdata;
    logic [NSRC-1:0] src_event;
    logic [NSRC-1:0] fire;
    logic [NSRC-1:0] en;
    logic            int_req;
    logic [DW-1:0]   int_vector;
    logic            irq;
    int              num_errors;
    int              compares;
    logic [AW-1:0]   rst_list [8] = '{OFS_CLR0, OFS_CLR1, OFS_CLR2, OFS_CTL,
                                       OFS_EN2, OFS_EN1, OFS_EN0, OFS_VC};

    imv_unit imv_unit_inst (
        .core_clk   (core_clk),
        .reset      (reset),
        .bus        (bus),
        .bus_rdata  (bus_rdata),
        .src_event  (src_event),
        .int_req    (int_req),
        .int_vector (int_vector),
        .irq        (irq)
    );
    imv_src_model imv_src_model_inst (
        .core_clk  (core_clk),
        .reset     (reset),
        .fire      (fire),
        .src_event (src_event)
    );

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // ----------------------------------------------------------
    // bus tasks and checking
    // ----------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge core_clk);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge core_clk);
        bus.wr    <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] e);
        @(posedge core_clk);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge core_clk);
        bus.rd   <= 1'b0;
        #1;
        chk(bus_rdata, e);
    endtask : rd_chk

    task automatic pulse(input logic [NSRC-1:0] v);
        @(posedge core_clk);
        fire <= v;
        @(posedge core_clk);
        fire <= '0;
        repeat (2) @(posedge core_clk);
        // step off the edge so registered outputs have settled
        #1;
    endtask : pulse

    task automatic settle;
        @(posedge core_clk);
        #1;
    endtask : settle

    task automatic tally_and_finish;
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial begin
        bus = '0;
        fire = '0;
        en = '0;
        reset = 1'b1;
        num_errors = 0;
        compares = 0;
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        foreach (rst_list[k]) rd_chk(rst_list[k], RST_BYTE);
        chk({7'h00, irq}, 8'h00);
        // masked sources still post
        pulse({NSRC{1'b1}});
        rd_chk(OFS_CLR0, 8'hFF);
        rd_chk(OFS_CLR1, 8'hFF);
        rd_chk(OFS_CLR2, 8'h7F);
        rd_chk(OFS_VC, VEC_NONE);
        chk({7'h00, int_req}, 8'h00);
        for (int i = 0; i < NSRC; i++) begin
            en = {NSRC{1'b1}} << i;
            wr(OFS_EN0, en[7:0]);
            wr(OFS_EN1, en[15:8]);
            wr(OFS_EN2, {1'b0, en[22:16]});
            rd_chk(OFS_VC, VEC_BASE + VEC_STEP * 8'(i));
        end
        rd_chk(OFS_EN2, 8'h40);
        rd_chk(OFS_EN1, 8'h00);
        wr(OFS_EN2, 8'hFF);
        rd_chk(OFS_EN2, EN2_MASK);
        wr(OFS_CTL, 8'h7F);
        rd_chk(OFS_CTL, 8'h00);
        // soft enable low: ones ignored, zeros clear
        wr(OFS_CLR0, 8'h0F);
        rd_chk(OFS_CLR0, 8'h0F);
        wr(OFS_CLR0, 8'hFF);
        rd_chk(OFS_CLR0, 8'h0F);
        // soft enable high: zeros ignored, ones post
        wr(OFS_CTL, 8'h80);
        rd_chk(OFS_CTL, 8'h80);
        wr(OFS_CLR0, 8'h00);
        rd_chk(OFS_CLR0, 8'h0F);
        wr(OFS_CLR0, 8'hF0);
        rd_chk(OFS_CLR0, 8'hFF);
        rd_chk(OFS_STAT, 8'h03);
        wr(OFS_EN0, 8'hFF);
        wr(OFS_EN1, 8'h00);
        wr(OFS_EN2, 8'h00);
        rd_chk(OFS_EN0, 8'hFF);
        rd_chk(OFS_VC, VEC_BASE);
        wr(OFS_VC, 8'hA5);
        rd_chk(OFS_VC, VEC_NONE);
        rd_chk(OFS_CLR0, 8'h00);
        rd_chk(OFS_CLR1, 8'hFF);
        // interrupt: raise, clear, mask
        wr(OFS_STAT, 8'hFF);
        wr(OFS_IMASK, 8'h01);
        pulse(23'h000002);
        chk({7'h00, irq}, 8'h01);
        chk({7'h00, int_req}, 8'h01);
        chk(int_vector, VEC_BASE + VEC_STEP);
        rd_chk(OFS_STAT, 8'h01);
        wr(OFS_STAT, 8'h01);
        settle();
        chk({7'h00, irq}, 8'h00);
        wr(OFS_IMASK, 8'h00);
        wr(OFS_VC, 8'h00);
        settle();
        chk({7'h00, irq}, 8'h00);
        chk({7'h00, int_req}, 8'h00);
        rd_chk(OFS_STAT, 8'h04);
        wr(OFS_IMASK, 8'h04);
        settle();
        chk({7'h00, irq}, 8'h01);
        wr(OFS_STAT, 8'h04);
        settle();
        chk({7'h00, irq}, 8'h00);
        // unmapped address reads zero, ignores writes
        wr(8'hE5, 8'hFF);
        rd_chk(8'hE5, 8'h00);
        tally_and_finish();
    end

    // hang guard, generous against roughly 300 cycles of tests
    initial begin
        repeat (5000) @(posedge core_clk);
        num_errors++;
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
